// file: hdl/dcrl_pkg.sv
// shared constants and types of the data cache control block
package dcrl_pkg;
	localparam int NUM_SETS = 32;
	localparam int NUM_WAYS = 32;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_AUX = 8'h04;
	localparam logic [7:0] REG_LOCK = 8'h08;
	localparam logic [7:0] REG_FSR = 8'h0c;
	localparam logic [7:0] REG_CMD = 8'h10;
	localparam logic [7:0] REG_STAT = 8'h14;
	localparam int CTRL_C_BIT = 2;
	localparam int AUX_K_BIT = 0;
	localparam int LOCK_EN_BIT = 0;
	localparam int FSR_PAR_BIT = 10;
	localparam int CMD_INV_ALL = 0;
	localparam int CMD_INV_ENT = 1;
	localparam int CMD_UNLOCK = 2;
	localparam int CMD_DRAIN = 3;
	localparam int CMD_SET_LSB = 8;
	localparam int CMD_WAY_LSB = 16;
	localparam int STAT_WB_LSB = 0;
	localparam int STAT_FB_LSB = 8;
	localparam int STAT_ST_LSB = 16;
	localparam logic [4:0] PTR_RESET = 5'h1f;
	localparam logic [4:0] WAY_LAST = 5'h1f;
	localparam logic [5:0] LOCK_MAX = 6'h1c;

	typedef enum logic [1:0] {
		KIND_LOAD = 2'b00,
		KIND_STORE = 2'b01,
		KIND_PLD = 2'b10,
		KIND_ALLOC = 2'b11
	} dcrl_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DRAIN = 2'b01,
		ST_WAIT_WR = 2'b10,
		ST_WAIT_FILL = 2'b11
	} dcrl_st_t;

	typedef struct packed {
		logic valid;
		dcrl_kind_t kind;
		logic mini;
		logic hit;
		logic [4:0] hit_way;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
		logic attr_c;
		logic attr_b;
		logic attr_x;
		logic wr_alloc;
		logic pld_err;
	} dcrl_acc_t;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
		logic [3:0] par;
	} dcrl_chk_t;

	typedef struct packed {
		logic valid;
		logic mini;
		logic [4:0] set;
		logic [4:0] way;
		logic lock;
		logic fetch;
	} dcrl_alloc_t;

	typedef struct packed {
		logic valid;
		logic [4:0] set;
		logic [4:0] way;
		logic [1:0] half;
	} dcrl_vict_t;

	typedef struct packed {
		logic valid;
		logic [27:0] addr;
		logic [127:0] data;
		logic [15:0] mask;
	} dcrl_wr_t;

	typedef struct packed {
		logic valid;
		logic [26:0] line;
	} dcrl_rd_t;
endpackage

// file: hdl/dcrl_parity.sv
`timescale 1ns/1ps
// byte parity generator and checker
module dcrl_parity (
	input wire logic [31:0] data,
	input wire logic [3:0] par,
	output logic [3:0] gen,
	output logic err
);
	// one even parity bit per byte
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			gen[i] = ^data[i*8 +: 8];
		end
		err = |(gen ^ par);
	end
endmodule

// file: hdl/dcrl_ctrl.sv
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// data cache replacement, locking, parity and write buffer control
// How it works
// R1: every set owns a round-robin pointer
// R2: fill advances only that set's pointer
// R3: reset points every pointer at way 31
// R4: after way 31 wrap past locked ways
// R5: mini cache pointer toggles between two lines
// R6: parity bit per data byte, none on tags
// R7: parity error aborts and sets status bit 10
// R8: parity abort is late, imprecise
// R9: reset disables caches, clears valid, unlocks all
// R10: caching needs control bit 2 and translation
// R11: invalidates never unlock locked lines
// R12: line allocate: no fetch, no mini effect
// R13: locked lines skipped by fills, 28 max
// R14: lock mode locks each new allocation
// R15: locked ways fill upward from way 0
// R16: software never locks into the mini cache
// R17: failing preload hint leaves cache untouched
// R18: resident data is not refetched, not locked
// R19: buffer always on, global merge enable
// R20: no merging keeps order; stores check fills
// R21: drain stalls until buffers are empty
// R22: unbuffered uncached store stalls until written
// R23: dirty victim halves leave as 4-word bursts
// R24: eight 16-byte entries, merge into any; the code merges into any live entry but the head
module dcrl_ctrl #(
	parameter int WB_DEPTH = 8,
	parameter int FB_DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic mmu_en,
	input wire dcrl_pkg::dcrl_acc_t acc,
	input wire dcrl_pkg::dcrl_chk_t rd_chk,
	input wire logic ext_wr_ack,
	input wire logic fill_done,
	output logic stall,
	output logic abort,
	output logic [3:0] wr_par,
	output dcrl_pkg::dcrl_alloc_t alloc,
	output dcrl_pkg::dcrl_vict_t vict,
	output dcrl_pkg::dcrl_wr_t ext_wr,
	output dcrl_pkg::dcrl_rd_t ext_rd
);
	import dcrl_pkg::*;
	localparam int WPW = $clog2(WB_DEPTH);
	localparam int FPW = $clog2(FB_DEPTH);

	function automatic logic live(int idx, int head, int cnt, int depth);
		return ((idx - head + depth) % depth) < cnt;
	endfunction

	function automatic logic [4:0] next_way(logic [4:0] ptr, logic [5:0] locked);
		return (ptr == WAY_LAST) ? locked[4:0] : ptr + 5'h01;
	endfunction

	logic [4:0] ptr_q [NUM_SETS];
	logic mptr_q [NUM_SETS];
	logic [5:0] lock_cnt_q [NUM_SETS];
	logic [NUM_WAYS-1:0] valid_q [NUM_SETS];
	logic [1:0] dirty_q [NUM_SETS][NUM_WAYS];
	logic ctrl_c_q, aux_k_q, lock_en_q, fsr_par_q;
	logic stall_q, abort_q;
	logic [3:0] wr_par_q;
	logic [31:0] rdata_q;
	dcrl_alloc_t alloc_q;
	dcrl_vict_t vict_q;
	dcrl_wr_t ext_wr_q;
	dcrl_rd_t ext_rd_q;
	dcrl_st_t st_q, st_d;
	logic [27:0] wb_addr_q [WB_DEPTH];
	logic [127:0] wb_data_q [WB_DEPTH];
	logic [15:0] wb_mask_q [WB_DEPTH];
	logic [WPW-1:0] wb_head_q, wb_tail_q, merge_idx, wb_idx;
	logic [WPW:0] wb_cnt_q, wb_cnt_d;
	logic [26:0] fb_line_q [FB_DEPTH];
	logic [FPW-1:0] fb_head_q, fb_iss_q, fb_tail_q;
	logic [FPW:0] fb_cnt_q, fb_cnt_d, fb_unis_q;
	logic take, is_store, cacheable, wback, need_fill, line_alloc, do_alloc;
	logic lock_now, coal_en, merge, wb_push, push_new, pop, fb_match;
	logic fb_push, fb_issue, fb_done, wr_capture, perr;
	logic cmd_wr, cmd_inv_all, cmd_inv_ent, cmd_unlock, cmd_drain;
	logic [4:0] set, way, cmd_set, cmd_way;
	logic [3:0] gen_par;
	logic [15:0] be_wide;
	logic [127:0] data_wide;

	assign reg_rdata = rdata_q;
	assign stall = stall_q;
	assign abort = abort_q;
	assign wr_par = wr_par_q;
	assign alloc = alloc_q;
	assign vict = vict_q;
	assign ext_wr = ext_wr_q;
	assign ext_rd = ext_rd_q;

	// R6: parity check on reads, generation on writes
	dcrl_parity u_chk (
		.data(rd_chk.data),
		.par(rd_chk.par),
		.gen(),
		.err(perr)
	);
	dcrl_parity u_gen (
		.data(acc.wdata),
		.par(4'h0),
		.gen(gen_par),
		.err()
	);

	// register commands
	assign cmd_wr = reg_wr && (reg_addr == REG_CMD);
	assign cmd_inv_all = cmd_wr && reg_wdata[CMD_INV_ALL];
	assign cmd_inv_ent = cmd_wr && reg_wdata[CMD_INV_ENT];
	assign cmd_unlock = cmd_wr && reg_wdata[CMD_UNLOCK];
	assign cmd_drain = cmd_wr && reg_wdata[CMD_DRAIN];
	assign cmd_set = reg_wdata[CMD_SET_LSB +: 5];
	assign cmd_way = reg_wdata[CMD_WAY_LSB +: 5];

	// access decode
	always_comb begin
		take = acc.valid && !stall_q;
		set = acc.addr[9:5];
		is_store = acc.kind == KIND_STORE;
		wback = acc.attr_c && acc.attr_b;
		// R10: cache enable and translation both needed
		cacheable = ctrl_c_q && mmu_en && acc.attr_c;
		// R17 R18: failed hints and hits never allocate, except a line allocate that hits
		need_fill = !acc.hit && cacheable && (acc.kind == KIND_LOAD ||
			(acc.kind == KIND_PLD && !acc.pld_err) || (is_store && acc.wr_alloc));
		// R12: line allocate skips the mini cache
		line_alloc = acc.kind == KIND_ALLOC && !acc.mini && ctrl_c_q && mmu_en;
		do_alloc = take && (need_fill || line_alloc);
		// R14 R16: lock only main-cache allocations, 28 max
		lock_now = lock_en_q && !acc.mini && lock_cnt_q[set] < LOCK_MAX;
		// R15 R5: locked ways ascend; mini uses one bit
		if (acc.mini) begin
			way = {4'h0, mptr_q[set]};
		end else if (lock_now) begin
			way = lock_cnt_q[set][4:0];
		end else begin
			way = ptr_q[set];
		end
		wb_push = take && is_store && !(acc.hit && wback) && !need_fill;
		// R19: global merge enable gates page attribute
		coal_en = aux_k_q && acc.attr_b;
		be_wide = 16'(acc.be) << {acc.addr[3:2], 2'b00};
		data_wide = 128'(acc.wdata) << {acc.addr[3:2], 5'b00000};
	end

	// R24: a store may merge with any live entry but the head
	always_comb begin
		merge = 1'b0;
		merge_idx = '0;
		for (int i = 0; i < WB_DEPTH; i++) begin
			if (coal_en && WPW'(i) != wb_head_q && live(i, wb_head_q, wb_cnt_q, WB_DEPTH)
				&& wb_addr_q[i] == acc.addr[31:4]) begin
				merge = 1'b1;
				merge_idx = WPW'(i);
			end
		end
		fb_match = 1'b0;
		for (int i = 0; i < FB_DEPTH; i++) begin
			if (live(i, fb_head_q, fb_cnt_q, FB_DEPTH) && fb_line_q[i] == acc.addr[31:5]) begin
				fb_match = 1'b1;
			end
		end
		push_new = wb_push && !merge;
		wb_idx = merge ? merge_idx : wb_tail_q;
		pop = ext_wr_ack && ext_wr_q.valid;
		wb_cnt_d = wb_cnt_q + (WPW+1)'(push_new) - (WPW+1)'(pop);
		wr_capture = !ext_wr_q.valid && wb_cnt_q != '0 && st_q != ST_WAIT_FILL;
		fb_push = do_alloc && need_fill;
		// R20: without merging, reads wait behind writes
		fb_issue = fb_unis_q != '0 && (aux_k_q || wb_cnt_q == '0);
		fb_done = fill_done && fb_cnt_q != fb_unis_q;
		fb_cnt_d = fb_cnt_q + (FPW+1)'(fb_push) - (FPW+1)'(fb_done);
	end

	// stall sequencing
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (cmd_drain) begin
					st_d = ST_DRAIN;
				// R22: uncached unbuffered store waits for its write
				end else if (wb_push && !acc.attr_c && !acc.attr_b && !acc.attr_x) begin
					st_d = ST_WAIT_WR;
				// R20: with merging on, a store to a line being filled waits for fills
				end else if (take && is_store && aux_k_q && fb_match) begin
					st_d = ST_WAIT_FILL;
				end
			end
			// R21: drain holds until both buffers are empty
			ST_DRAIN: begin
				if (wb_cnt_q == '0 && fb_cnt_q == '0) begin
					st_d = ST_IDLE;
				end
			end
			ST_WAIT_WR: begin
				if (wb_cnt_q == '0) begin
					st_d = ST_IDLE;
				end
			end
			ST_WAIT_FILL: begin
				if (fb_cnt_q == '0) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_q <= ST_IDLE;
			stall_q <= 1'b0;
		end else begin
			st_q <= st_d;
			stall_q <= st_d != ST_IDLE || wb_cnt_d == (WPW+1)'(WB_DEPTH) ||
				fb_cnt_d == (FPW+1)'(FB_DEPTH);
		end
	end

	// control registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			// R9: caches come up disabled
			ctrl_c_q <= 1'b0;
			aux_k_q <= 1'b0;
			lock_en_q <= 1'b0;
			fsr_par_q <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == REG_CTRL) begin
				ctrl_c_q <= reg_wdata[CTRL_C_BIT];
			end
			if (reg_wr && reg_addr == REG_AUX) begin
				aux_k_q <= reg_wdata[AUX_K_BIT];
			end
			if (reg_wr && reg_addr == REG_LOCK) begin
				lock_en_q <= reg_wdata[LOCK_EN_BIT];
			end
			// R7: a parity error sets the status bit, set wins
			if (rd_chk.valid && perr) begin
				fsr_par_q <= 1'b1;
			end else if (reg_wr && reg_addr == REG_FSR) begin
				fsr_par_q <= reg_wdata[FSR_PAR_BIT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= 32'h0000_0000;
			if (reg_rd) begin
				case (reg_addr)
					REG_CTRL: rdata_q[CTRL_C_BIT] <= ctrl_c_q;
					REG_AUX: rdata_q[AUX_K_BIT] <= aux_k_q;
					REG_LOCK: rdata_q[LOCK_EN_BIT] <= lock_en_q;
					REG_FSR: rdata_q[FSR_PAR_BIT] <= fsr_par_q;
					REG_STAT: begin
						rdata_q[STAT_WB_LSB +: 8] <= 8'(wb_cnt_q);
						rdata_q[STAT_FB_LSB +: 8] <= 8'(fb_cnt_q);
						rdata_q[STAT_ST_LSB +: 2] <= st_q;
					end
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// per-set replacement, lock and line state
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int s = 0; s < NUM_SETS; s++) begin
				// R3 R9: pointers at way 31, all invalid, unlocked
				ptr_q[s] <= PTR_RESET;
				mptr_q[s] <= 1'b0;
				lock_cnt_q[s] <= 6'h00;
				valid_q[s] <= '0;
				for (int w = 0; w < NUM_WAYS; w++) begin
					dirty_q[s][w] <= 2'b00;
				end
			end
		end else begin
			if (cmd_unlock) begin
				for (int s = 0; s < NUM_SETS; s++) begin
					lock_cnt_q[s] <= 6'h00;
				end
			end
			// R11: invalidate-all leaves locked ways alone; entry invalidate clears any way
			if (cmd_inv_all) begin
				for (int s = 0; s < NUM_SETS; s++) begin
					for (int w = 0; w < NUM_WAYS; w++) begin
						if (6'(w) >= lock_cnt_q[s]) begin
							valid_q[s][w] <= 1'b0;
							dirty_q[s][w] <= 2'b00;
						end
					end
				end
			end
			if (cmd_inv_ent) begin
				valid_q[cmd_set][cmd_way] <= 1'b0;
			end
			if (take && is_store && acc.hit && wback && !acc.mini) begin
				dirty_q[set][acc.hit_way][acc.addr[4]] <= 1'b1;
			end
			if (do_alloc && !acc.mini) begin
				valid_q[set][way] <= 1'b1;
				dirty_q[set][way] <= (is_store && wback) ? {acc.addr[4], !acc.addr[4]} : 2'b00;
				if (lock_now) begin
					// R13 R14: lock the way and move the pointer past it
					lock_cnt_q[set] <= lock_cnt_q[set] + 6'h01;
					if ({1'b0, ptr_q[set]} < lock_cnt_q[set] + 6'h01) begin
						ptr_q[set] <= lock_cnt_q[set][4:0] + 5'h01;
					end
				end else begin
					// R1 R2 R4: step this set only, wrap past locks
					ptr_q[set] <= next_way(ptr_q[set], lock_cnt_q[set]);
				end
			end
			// R5: mini pointer names the older of two lines
			if (do_alloc && acc.mini) begin
				mptr_q[set] <= !mptr_q[set];
			end
		end
	end

	// allocation, victim and parity outputs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			alloc_q <= '0;
			vict_q <= '0;
			abort_q <= 1'b0;
			wr_par_q <= 4'h0;
		end else begin
			alloc_q.valid <= do_alloc;
			alloc_q.mini <= acc.mini;
			alloc_q.set <= set;
			alloc_q.way <= way;
			alloc_q.lock <= do_alloc && lock_now;
			// R12: line allocate never fetches
			alloc_q.fetch <= do_alloc && need_fill;
			// R23: dirty halves of a valid victim go out as bursts
			vict_q.valid <= do_alloc && !acc.mini && valid_q[set][way] &&
				dirty_q[set][way] != 2'b00;
			vict_q.set <= set;
			vict_q.way <= way;
			vict_q.half <= dirty_q[set][way];
			// R8: abort raised a cycle late, load data not held back
			abort_q <= rd_chk.valid && perr;
			wr_par_q <= gen_par;
		end
	end

	// write buffer storage
	always_ff @(posedge clk) begin
		if (wb_push) begin
			wb_addr_q[wb_idx] <= acc.addr[31:4];
			if (!merge) begin
				wb_mask_q[wb_idx] <= be_wide;
				wb_data_q[wb_idx] <= data_wide;
			end else begin
				wb_mask_q[wb_idx] <= wb_mask_q[wb_idx] | be_wide;
				for (int b = 0; b < 16; b++) begin
					if (be_wide[b]) begin
						wb_data_q[wb_idx][b*8 +: 8] <= data_wide[b*8 +: 8];
					end
				end
			end
		end
	end

	// R19: write buffer pointers, always active
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wb_head_q <= '0;
			wb_tail_q <= '0;
			wb_cnt_q <= '0;
			ext_wr_q <= '0;
		end else begin
			wb_cnt_q <= wb_cnt_d;
			if (push_new) begin
				wb_tail_q <= wb_tail_q + WPW'(1);
			end
			if (pop) begin
				wb_head_q <= wb_head_q + WPW'(1);
				ext_wr_q.valid <= 1'b0;
			end else if (wr_capture) begin
				ext_wr_q <= {1'b1, wb_addr_q[wb_head_q], wb_data_q[wb_head_q],
					wb_mask_q[wb_head_q]};
			end
		end
	end

	// fill buffer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fb_head_q <= '0;
			fb_iss_q <= '0;
			fb_tail_q <= '0;
			fb_cnt_q <= '0;
			fb_unis_q <= '0;
			ext_rd_q <= '0;
		end else begin
			fb_cnt_q <= fb_cnt_d;
			fb_unis_q <= fb_unis_q + (FPW+1)'(fb_push) - (FPW+1)'(fb_issue);
			if (fb_push) begin
				fb_line_q[fb_tail_q] <= acc.addr[31:5];
				fb_tail_q <= fb_tail_q + FPW'(1);
			end
			if (fb_done) begin
				fb_head_q <= fb_head_q + FPW'(1);
			end
			ext_rd_q.valid <= fb_issue;
			ext_rd_q.line <= fb_line_q[fb_iss_q];
			if (fb_issue) begin
				fb_iss_q <= fb_iss_q + FPW'(1);
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	ptr_step_a: assert property (alloc_q.valid && !alloc_q.mini && !alloc_q.lock && // R2
		alloc_q.way != WAY_LAST |-> ptr_q[alloc_q.set] == alloc_q.way + 5'h01)
		else $error("pointer did not step after fill");
	ptr_wrap_a: assert property (alloc_q.valid && !alloc_q.mini && !alloc_q.lock && // R4
		alloc_q.way == WAY_LAST && !$past(cmd_unlock) |->
		ptr_q[alloc_q.set] == lock_cnt_q[alloc_q.set][4:0])
		else $error("pointer did not wrap to first free way");
	lock_skip_a: assert property (alloc_q.valid && !alloc_q.mini && !alloc_q.lock && // R13
		!$past(cmd_unlock) |-> {1'b0, alloc_q.way} >= lock_cnt_q[alloc_q.set])
		else $error("fill landed on a locked way");
	lock_order_a: assert property (alloc_q.lock && !$past(cmd_unlock) |-> // R15
		lock_cnt_q[alloc_q.set] == {1'b0, alloc_q.way} + 6'h01 && alloc_q.way <= 5'h1b)
		else $error("locked way out of order");
	mini_toggle_a: assert property (alloc_q.valid && alloc_q.mini |-> // R5
		mptr_q[alloc_q.set] != alloc_q.way[0])
		else $error("mini pointer did not move");
	par_abort_a: assert property (rd_chk.valid && perr |=> abort_q && fsr_par_q) // R7
		else $error("parity error without abort");
	drain_hold_a: assert property (cmd_drain && st_q == ST_IDLE |=> // R21
		st_q == ST_DRAIN && stall_q)
		else $error("drain did not stall");
	sync_wr_a: assert property (st_q == ST_WAIT_WR && wb_cnt_q != '0 |-> stall_q) // R22
		else $error("uncached store released early");
	no_merge_a: assert property (push_new == 1'b0 && wb_push && !pop |-> aux_k_q) // R19
		else $error("merge while merging disabled");
	pld_err_a: assert property (take && acc.kind == KIND_PLD && acc.pld_err // R17
		|=> !alloc_q.valid)
		else $error("failed hint changed the cache");
	line_alloc_a: assert property (take && line_alloc |=> alloc_q.valid && // R12
		!alloc_q.fetch && !alloc_q.mini)
		else $error("line allocate fetched");

	wrap_c: cover property (alloc_q.valid && alloc_q.way == WAY_LAST);
	lock_c: cover property (alloc_q.lock);
	merge_c: cover property (wb_push && merge);
	drain_c: cover property (st_q == ST_DRAIN ##1 st_q == ST_IDLE);
endmodule

// file: tb/dcrl_mem_model.sv
`timescale 1ns/1ps
// external memory model answering buffered writes and line fills
module dcrl_mem_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic slow,
	input wire dcrl_pkg::dcrl_wr_t ext_wr,
	input wire dcrl_pkg::dcrl_rd_t ext_rd,
	output logic ext_wr_ack,
	output logic fill_done,
	output logic [7:0] wr_count,
	output logic [15:0] last_mask
);
	import dcrl_pkg::*;
	logic [4:0] wr_cnt_q;
	logic [4:0] rd_cnt_q;
	logic [3:0] pend_q;
	logic [4:0] dly;
	logic fire;
	assign dly = slow ? 5'h0c : 5'h02;
	assign fire = (pend_q != 4'h0) && (rd_cnt_q >= dly);
	// write completes after a delay, counted
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ext_wr_ack <= 1'b0;
			wr_cnt_q <= 5'h00;
			wr_count <= 8'h00;
			last_mask <= 16'h0000;
		end else if (ext_wr_ack) begin
			ext_wr_ack <= 1'b0;
			wr_cnt_q <= 5'h00;
		end else if (ext_wr.valid && wr_cnt_q >= dly) begin
			ext_wr_ack <= 1'b1;
			wr_count <= wr_count + 8'h01;
			last_mask <= ext_wr.mask;
		end else if (ext_wr.valid) begin
			wr_cnt_q <= wr_cnt_q + 5'h01;
		end else begin
			wr_cnt_q <= 5'h00;
		end
	end
	// fills return oldest first
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pend_q <= 4'h0;
			rd_cnt_q <= 5'h00;
			fill_done <= 1'b0;
		end else begin
			fill_done <= fire;
			rd_cnt_q <= fire ? 5'h00 : (pend_q != 4'h0) ? rd_cnt_q + 5'h01 : 5'h00;
			pend_q <= pend_q + {3'h0, ext_rd.valid} - {3'h0, fire};
		end
	end
endmodule

// file: tb/data_cache_replace_lock_wbuf_test.sv
`timescale 1ns/1ps
// self-checking bench of the data cache control block
module data_cache_replace_lock_wbuf_test;
	import dcrl_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic mmu_en = 1'b0;
	logic slow = 1'b0;
	dcrl_acc_t acc = '0;
	dcrl_chk_t rd_chk = '0;
	logic [31:0] reg_rdata;
	logic ext_wr_ack, fill_done, stall, abort;
	logic [3:0] wr_par;
	dcrl_alloc_t alloc;
	dcrl_vict_t vict;
	dcrl_wr_t ext_wr;
	dcrl_rd_t ext_rd;
	logic [7:0] wr_count;
	logic [7:0] n0;
	logic [15:0] last_mask;
	logic [31:0] lfsr_q = 32'h8278_9c2f;
	logic [31:0] v;
	logic [31:0] d;
	logic [4:0] w;
	logic [4:0] w0;
	dcrl_acc_t a;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;

	always #10 clk = ~clk;

	dcrl_ctrl i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mmu_en(mmu_en), .acc(acc),
		.rd_chk(rd_chk), .ext_wr_ack(ext_wr_ack), .fill_done(fill_done), .stall(stall),
		.abort(abort), .wr_par(wr_par), .alloc(alloc), .vict(vict), .ext_wr(ext_wr),
		.ext_rd(ext_rd));
	dcrl_mem_model i_mem (.clk(clk), .rst_b(rst_b), .slow(slow), .ext_wr(ext_wr),
		.ext_rd(ext_rd), .ext_wr_ack(ext_wr_ack), .fill_done(fill_done),
		.wr_count(wr_count), .last_mask(last_mask));

	function automatic logic [31:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q;
	endfunction
	function automatic logic [3:0] par_of(input logic [31:0] x);
		for (int i = 0; i < 4; i++) par_of[i] = ^x[8*i +: 8];
	endfunction
	function automatic dcrl_acc_t mk(input dcrl_kind_t k, input logic [31:0] ad, input logic c,
		input logic b);
		mk = '0;
		mk.valid = 1'b1;
		mk.kind = k;
		mk.addr = ad;
		mk.attr_c = c;
		mk.attr_b = b;
		mk.be = 4'hf;
		mk.wdata = rnd();
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic reg_write(input logic [7:0] ad, input logic [31:0] x);
		@(posedge clk);
		reg_addr <= ad;
		reg_wdata <= x;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] ad, output logic [31:0] x);
		@(posedge clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 x = reg_rdata;
	endtask
	task automatic issue(input dcrl_acc_t r);
		int n;
		n = 0;
		@(posedge clk);
		acc <= r;
		#1;
		while (stall !== 1'b0 && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("stall release", 32'd0, 32'(stall));
		@(posedge clk);
		acc <= '0;
		#1;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (stall !== 1'b0 && n < 600) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("idle reached", 32'd0, 32'(stall));
	endtask
	task automatic miss(input logic [4:0] s, output logic [4:0] wy);
		issue(mk(KIND_LOAD, {22'h0, s, 5'h00}, 1'b1, 1'b1));
		chk("alloc valid", 32'd1, 32'(alloc.valid));
		wy = alloc.way;
	endtask
	task automatic run_wrap(input logic [4:0] s, input logic [4:0] lo);
		logic [4:0] p;
		logic [4:0] wy;
		p = 5'h00;
		for (int i = 0; i < 34; i++) begin
			miss(s, wy);
			if (i > 0 && p == WAY_LAST) begin
				chk("wrap way", 32'(lo), 32'(wy));
				break;
			end
			if (wy < lo) chk("locked way skipped", 32'(lo), 32'(wy));
			p = wy;
		end
	endtask
	task automatic store3_drain();
		for (int i = 0; i < 3; i++) issue(mk(KIND_STORE, 32'h0000_0300 + 32'(i * 4), 1'b0, 1'b1));
		reg_write(REG_CMD, 32'h0000_0008);
		@(posedge clk);
		#1 chk("drain stall", 32'd1, 32'(stall));
		wait_idle();
		reg_read(REG_STAT, v);
		chk("drain empty", 32'h0000_0000, v);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		reg_read(REG_CTRL, v);
		chk("ctrl reset", 32'h0000_0000, v);
		reg_read(REG_STAT, v);
		chk("stat reset", 32'h0000_0000, v);
		reg_read(8'h40, v);
		chk("unmapped read", 32'h0000_0000, v);
		mmu_en <= 1'b1;
		issue(mk(KIND_LOAD, 32'h0000_0120, 1'b1, 1'b1));
		chk("alloc disabled", 32'd0, 32'(alloc.valid));
		reg_write(REG_CTRL, 32'h0000_0004);
		mmu_en <= 1'b0;
		issue(mk(KIND_LOAD, 32'h0000_0120, 1'b1, 1'b1));
		chk("alloc no mmu", 32'd0, 32'(alloc.valid));
		mmu_en <= 1'b1;
		miss(5'd9, w);
		chk("first way", 32'd31, 32'(w));
		miss(5'd9, w);
		chk("wrap to zero", 32'd0, 32'(w));
		miss(5'd9, w);
		chk("next way", 32'd1, 32'(w));
		miss(5'd10, w);
		chk("other set", 32'd31, 32'(w));
		issue(mk(KIND_ALLOC, 32'h0000_0160, 1'b1, 1'b1));
		chk("alloc no fetch", 32'd0, 32'(alloc.fetch));
		a = mk(KIND_ALLOC, 32'h0000_0160, 1'b1, 1'b1);
		a.mini = 1'b1;
		issue(a);
		chk("alloc mini", 32'd0, 32'(alloc.valid));
		for (int i = 0; i < 4; i++) begin
			a = mk(KIND_PLD, {rnd() & 32'hffff_fc00} | 32'h0000_01e0, 1'b1, 1'b1);
			a.pld_err = 1'b1;
			issue(a);
			chk("pld error", 32'd0, 32'(alloc.valid));
			chk("write parity", 32'(par_of(a.wdata)), 32'(wr_par));
		end
		// lock mode only for data cache requests
		reg_write(REG_LOCK, 32'h0000_0001);
		a = mk(KIND_LOAD, 32'h0000_0180, 1'b1, 1'b1);
		a.hit = 1'b1;
		issue(a);
		chk("resident not locked", 32'd0, 32'(alloc.valid));
		miss(5'd12, w);
		chk("lock way", 32'd0, 32'(w));
		chk("lock flag", 32'd1, 32'(alloc.lock));
		miss(5'd12, w);
		chk("lock way next", 32'd1, 32'(w));
		reg_write(REG_LOCK, 32'h0000_0000);
		run_wrap(5'd12, 5'd2);
		reg_write(REG_CMD, 32'h0000_0c03);
		run_wrap(5'd12, 5'd2);
		reg_write(REG_CMD, 32'h0000_0004);
		run_wrap(5'd12, 5'd0);
		a = mk(KIND_LOAD, 32'h0000_01a0, 1'b1, 1'b1);
		a.mini = 1'b1;
		issue(a);
		chk("mini alloc", 32'd1, 32'(alloc.mini));
		w0 = alloc.way;
		issue(a);
		chk("mini other line", 32'd1, 32'(alloc.way != w0));
		issue(a);
		chk("mini back", 32'(w0), 32'(alloc.way));
		miss(5'd14, w);
		a = mk(KIND_STORE, 32'h0000_01d0, 1'b1, 1'b1);
		a.hit = 1'b1;
		a.hit_way = 5'd31;
		issue(a);
		for (int i = 0; i < 32; i++) miss(5'd14, w);
		chk("victim", {19'h0, 1'b1, 5'd14, 5'd31, 2'b10}, 32'(vict));
		for (int i = 0; i < 6; i++) begin
			d = rnd();
			@(posedge clk);
			rd_chk <= '{valid: 1'b1, data: d, par: par_of(d) ^ {3'h0, i[0]}};
			@(posedge clk);
			rd_chk <= '0;
			#1 chk("abort", 32'(i[0]), 32'(abort));
		end
		reg_read(REG_FSR, v);
		chk("fault bit", 32'd1, 32'(v[FSR_PAR_BIT]));
		slow <= 1'b1;
		n0 = wr_count;
		issue(mk(KIND_STORE, 32'h0000_0200, 1'b0, 1'b0));
		@(posedge clk);
		#1 chk("store stall", 32'd1, 32'(stall));
		wait_idle();
		chk("write done", 32'(n0 + 8'h01), 32'(wr_count));
		n0 = wr_count;
		store3_drain();
		chk("unmerged writes", 32'(n0 + 8'h03), 32'(wr_count));
		reg_write(REG_AUX, 32'h0000_0001);
		n0 = wr_count;
		store3_drain();
		chk("merged writes", 32'(n0 + 8'h02), 32'(wr_count));
		chk("merged mask", 32'h0000_0ff0, 32'(last_mask));
		// store to a line still being filled waits
		issue(mk(KIND_LOAD, 32'h0000_0220, 1'b1, 1'b1));
		issue(mk(KIND_STORE, 32'h0000_0224, 1'b1, 1'b1));
		chk("fill stall", 32'd1, 32'(stall));
		wait_idle();
		give_verdict();
	end
endmodule
